// ---- cmb_pkg.sv ----
// package for the channel mode and bit-bang i/o block
// assumes a 100 MHz system clock and an apb3 register master
package cmb_pkg;

  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int ENG_MAX_HZ = 30_000_000;
  localparam int ENG_HALF_CYC = (CLK_HZ + 2 * ENG_MAX_HZ - 1) / (2 * ENG_MAX_HZ);
  localparam int SBB_SETUP_CYC = 1;

  // buffers
  localparam int NUM_CH = 4;
  localparam int NUM_ENG_CH = 2;
  localparam int BUF_DEPTH = 2048;
  localparam int BUF_AW = 11;

  // register map
  localparam logic [11:0] MODE_BASE = 12'h000;
  localparam logic [11:0] DIR_BASE = 12'h010;
  localparam logic [11:0] PINS_OFF = 12'h020;
  localparam logic [11:0] STAT_OFF = 12'h024;
  localparam logic [7:0] DIR_RST = 8'h00;

  // mode-select codes
  localparam logic [7:0] CODE_UART = 8'h00;
  localparam logic [7:0] CODE_ABB = 8'h01;
  localparam logic [7:0] CODE_ENG = 8'h02;
  localparam logic [7:0] CODE_SBB = 8'h04;

  // engine command opcodes
  localparam logic [7:0] OP_SHIFT = 8'h10;
  localparam logic [7:0] OP_DIV = 8'h11;
  localparam logic [7:0] OP_ADAPT_ON = 8'h12;
  localparam logic [7:0] OP_ADAPT_OFF = 8'h13;

  // engine pin positions
  localparam int PIN_CLK = 0;
  localparam int PIN_DOUT = 1;
  localparam int PIN_DIN = 2;
  localparam int PIN_RET_CLK = 7;
  localparam logic [7:0] ENG_OUT_MASK = 8'h0b;
  localparam logic [7:0] DIV_RST = 8'h00;

  typedef enum logic [1:0] {
    MODE_UART,
    MODE_ABB,
    MODE_ENG,
    MODE_SBB
  } cmb_mode_e;

  typedef struct packed {
    cmb_mode_e mode;
    logic [7:0] dir;
    logic rs485_en;
  } cmb_cfg_s;

  typedef struct packed {
    logic adaptive;
    logic rs485_on;
  } cmb_stat_s;

endpackage

// ---- cmb_channel_io.sv ----
// channel mode control and bit-bang engines for four channels, serial engine for two of them
// assumes synchronous pin inputs, an external uart and baud generator per channel
//
// Functional notes
// - all channels reset into uart mode
// - each channel keeps its own mode
// - code 2 selects engine, 0 back to uart
// - code 1 selects asynchronous bit-bang
// - code 4 selects synchronous bit-bang
// - serial engine only on channels a, b
// - stored config only enables rs485 driver
// - rs485 enable only while uart sends
// - power enable output flags usb suspend
// - engine takes commands from host stream
// - engine clock up to 100 MHz / 7 (about 14.3 MHz), divisible
// - adaptive: wait returned clock before data change
// - adaptive clocking off until commanded
// - per-pin direction; only outputs driven
// - async bit-bang paced by baud tick
// - async outputs change on byte and tick
// - sync bit-bang updates and samples per byte
// - sync stalls until upstream buffer has room
// - sample pins before driving new byte
// - one setup cycle after outputs change
// - strobes internal only, never on pins
// - 2 kbyte transmit and receive buffers
`timescale 1ns/1ps
`default_nettype none

module cmb_chan #(
  parameter bit HAS_ENGINE = 1'b0
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire cmb_pkg::cmb_cfg_s i_cfg,
  input wire logic i_baud_tick,
  input wire logic i_uart_busy,
  input wire logic i_uart_tx_ready,
  output logic o_uart_tx_valid,
  output logic [7:0] o_uart_tx_data,
  input wire logic i_uart_rx_valid,
  input wire logic [7:0] i_uart_rx_data,
  input wire logic i_host_wr_valid,
  input wire logic [7:0] i_host_wr_data,
  output logic o_host_wr_ready,
  output logic o_host_rd_valid,
  output logic [7:0] o_host_rd_data,
  input wire logic i_host_rd_ready,
  input wire logic [7:0] i_pin_in,
  output logic [7:0] o_pin_out,
  output logic [7:0] o_pin_oe_n,
  output cmb_pkg::cmb_stat_s o_stat
);
  typedef enum logic [1:0] {ES_CMD, ES_ARG, ES_LO, ES_HI} cmb_eng_e;
  typedef enum logic {SB_IDLE, SB_SETUP} cmb_sbb_e;

  // 2 kbyte buffers each way
  logic [7:0] dn_mem [cmb_pkg::BUF_DEPTH];
  logic [7:0] up_mem [cmb_pkg::BUF_DEPTH];
  logic [cmb_pkg::BUF_AW-1:0] dn_wp_ff, dn_rp_ff, up_wp_ff, up_rp_ff;
  logic [cmb_pkg::BUF_AW:0] dn_cnt_ff, up_cnt_ff;
  logic dn_empty, up_room, dn_push, dn_pop, up_push, up_pop;
  logic [7:0] dn_data, up_data;

  cmb_pkg::cmb_mode_e mode_q_ff;
  logic mode_chg;
  cmb_eng_e eng_st_ff;
  cmb_sbb_e sbb_st_ff;
  logic [7:0] op_ff, sh_ff, rx_ff, div_ff;
  logic [2:0] bit_ff;
  logic [9:0] cnt_ff;
  logic [9:0] half_cyc;
  logic eng_clk_ff, eng_do_ff, adapt_ff, eng_pop, eng_push;
  logic uart_load, abb_load, read_strobe_n, write_strobe_n;
  logic [7:0] nxt_oe_n;

  assign dn_empty = (dn_cnt_ff == '0);
  assign up_room = (up_cnt_ff != (cmb_pkg::BUF_AW+1)'(cmb_pkg::BUF_DEPTH));
  assign dn_data = dn_mem[dn_rp_ff];
  assign dn_push = i_host_wr_valid && o_host_wr_ready;
  assign mode_chg = (i_cfg.mode != mode_q_ff);
  assign half_cyc = 10'((div_ff + 9'd1) * cmb_pkg::ENG_HALF_CYC);

  assign uart_load = (i_cfg.mode == cmb_pkg::MODE_UART) && !dn_empty && (!o_uart_tx_valid || i_uart_tx_ready);
  assign abb_load = (i_cfg.mode == cmb_pkg::MODE_ABB) && !dn_empty && i_baud_tick;
  // sample only when a byte is waiting and upstream has room
  assign read_strobe_n = !((i_cfg.mode == cmb_pkg::MODE_SBB) && (sbb_st_ff == SB_IDLE) && !dn_empty && up_room
                           && !mode_chg);
  assign write_strobe_n = !(sbb_st_ff == SB_SETUP);
  assign dn_pop = uart_load || abb_load || !read_strobe_n || eng_pop;
  assign up_push = (!read_strobe_n) || eng_push
                   || ((i_cfg.mode == cmb_pkg::MODE_UART) && i_uart_rx_valid && up_room);
  assign up_data = !read_strobe_n ? i_pin_in : (eng_push ? rx_ff : i_uart_rx_data);
  assign up_pop = (up_cnt_ff != '0) && (!o_host_rd_valid || i_host_rd_ready);

  // downstream buffer
  always_ff @(posedge i_sys_clk) begin
    if (dn_push) begin
      dn_mem[dn_wp_ff] <= i_host_wr_data;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dn_wp_ff <= '0;
      dn_rp_ff <= '0;
      dn_cnt_ff <= '0;
      o_host_wr_ready <= 1'b0;
    end else begin
      dn_wp_ff <= dn_wp_ff + BUF_AW_ONE(dn_push);
      dn_rp_ff <= dn_rp_ff + BUF_AW_ONE(dn_pop);
      dn_cnt_ff <= dn_cnt_ff + {{cmb_pkg::BUF_AW{1'b0}}, dn_push} - {{cmb_pkg::BUF_AW{1'b0}}, dn_pop};
      o_host_wr_ready <= ((dn_cnt_ff + {{cmb_pkg::BUF_AW{1'b0}}, dn_push} - {{cmb_pkg::BUF_AW{1'b0}}, dn_pop})
                          != (cmb_pkg::BUF_AW+1)'(cmb_pkg::BUF_DEPTH));
    end
  end

  function automatic logic [cmb_pkg::BUF_AW-1:0] BUF_AW_ONE(input logic b);
    BUF_AW_ONE = {{(cmb_pkg::BUF_AW-1){1'b0}}, b};
  endfunction

  // upstream buffer
  always_ff @(posedge i_sys_clk) begin
    if (up_push) begin
      up_mem[up_wp_ff] <= up_data;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      up_wp_ff <= '0;
      up_rp_ff <= '0;
      up_cnt_ff <= '0;
      o_host_rd_valid <= 1'b0;
      o_host_rd_data <= 8'h00;
    end else begin
      up_wp_ff <= up_wp_ff + BUF_AW_ONE(up_push);
      up_rp_ff <= up_rp_ff + BUF_AW_ONE(up_pop);
      up_cnt_ff <= up_cnt_ff + {{cmb_pkg::BUF_AW{1'b0}}, up_push} - {{cmb_pkg::BUF_AW{1'b0}}, up_pop};
      if (up_pop) begin
        o_host_rd_valid <= 1'b1;
        o_host_rd_data <= up_mem[up_rp_ff];
      end else if (i_host_rd_ready) begin
        o_host_rd_valid <= 1'b0;
      end
    end
  end

  // uart side
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_uart_tx_valid <= 1'b0;
      o_uart_tx_data <= 8'h00;
      mode_q_ff <= cmb_pkg::MODE_UART;
    end else begin
      mode_q_ff <= i_cfg.mode;
      if (uart_load) begin
        o_uart_tx_valid <= 1'b1;
        o_uart_tx_data <= dn_data;
      end else if (i_uart_tx_ready || (i_cfg.mode != cmb_pkg::MODE_UART)) begin
        o_uart_tx_valid <= 1'b0;
      end
    end
  end

  // rs485 driver enable and status
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_stat <= '0;
    end else begin
      o_stat.rs485_on <= i_cfg.rs485_en && (i_cfg.mode == cmb_pkg::MODE_UART) && i_uart_busy;
      o_stat.adaptive <= adapt_ff;
    end
  end

  // synchronous bit-bang sequence
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sbb_st_ff <= SB_IDLE;
    end else if (mode_chg) begin
      sbb_st_ff <= SB_IDLE;
    end else if (!read_strobe_n) begin
      sbb_st_ff <= SB_SETUP;
    end else if (!write_strobe_n) begin
      sbb_st_ff <= SB_IDLE;
    end
  end

  // synchronous serial engine, command driven
  generate
    if (HAS_ENGINE) begin : g_eng
      assign eng_pop = (i_cfg.mode == cmb_pkg::MODE_ENG) && !mode_chg && !dn_empty
                       && ((eng_st_ff == ES_CMD) || ((eng_st_ff == ES_ARG) && (op_ff != cmb_pkg::OP_SHIFT || up_room)));
      assign eng_push = (eng_st_ff == ES_HI) && (cnt_ff == '0) && !eng_clk_ff && (bit_ff == 3'd0)
                        && !(adapt_ff && i_pin_in[cmb_pkg::PIN_RET_CLK]);
      always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          eng_st_ff <= ES_CMD;
          op_ff <= 8'h00;
          sh_ff <= 8'h00;
          rx_ff <= 8'h00;
          div_ff <= cmb_pkg::DIV_RST;
          bit_ff <= 3'd0;
          cnt_ff <= '0;
          eng_clk_ff <= 1'b0;
          eng_do_ff <= 1'b0;
          adapt_ff <= 1'b0;
        end else if (mode_chg) begin
          eng_st_ff <= ES_CMD;
          eng_clk_ff <= 1'b0;
        end else begin
          case (eng_st_ff)
            ES_CMD: begin
              if (eng_pop) begin
                op_ff <= dn_data;
                case (dn_data)
                  cmb_pkg::OP_SHIFT: eng_st_ff <= ES_ARG;
                  cmb_pkg::OP_DIV: eng_st_ff <= ES_ARG;
                  cmb_pkg::OP_ADAPT_ON: adapt_ff <= 1'b1;
                  cmb_pkg::OP_ADAPT_OFF: adapt_ff <= 1'b0;
                  default: eng_st_ff <= ES_CMD;
                endcase
              end
            end
            ES_ARG: begin
              if (eng_pop) begin
                if (op_ff == cmb_pkg::OP_DIV) begin
                  div_ff <= dn_data;
                  eng_st_ff <= ES_CMD;
                end else begin
                  sh_ff <= dn_data;
                  eng_do_ff <= dn_data[7];
                  bit_ff <= 3'd7;
                  cnt_ff <= half_cyc;
                  eng_st_ff <= ES_LO;
                end
              end
            end
            ES_LO: begin
              if (cnt_ff != '0) begin
                cnt_ff <= cnt_ff - 10'd1;
              end else begin
                eng_clk_ff <= 1'b1;
                rx_ff <= {rx_ff[6:0], i_pin_in[cmb_pkg::PIN_DIN]};
                cnt_ff <= half_cyc;
                eng_st_ff <= ES_HI;
              end
            end
            ES_HI: begin
              if (cnt_ff != '0) begin
                cnt_ff <= cnt_ff - 10'd1;
              end else if (eng_clk_ff) begin
                if (!adapt_ff || i_pin_in[cmb_pkg::PIN_RET_CLK]) begin
                  eng_clk_ff <= 1'b0;
                end
              end else if (!(adapt_ff && i_pin_in[cmb_pkg::PIN_RET_CLK])) begin
                // with adaptive on, data changes only once the returned clock is low again
                if (bit_ff == 3'd0) begin
                  eng_st_ff <= ES_CMD;
                end else begin
                  bit_ff <= bit_ff - 3'd1;
                  eng_do_ff <= sh_ff[bit_ff - 3'd1];
                  cnt_ff <= half_cyc;
                  eng_st_ff <= ES_LO;
                end
              end
            end
            default: eng_st_ff <= ES_CMD;
          endcase
        end
      end
    end else begin : g_no_eng
      assign eng_pop = 1'b0;
      assign eng_push = 1'b0;
      always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          eng_st_ff <= ES_CMD;
          op_ff <= 8'h00;
          sh_ff <= 8'h00;
          rx_ff <= 8'h00;
          div_ff <= cmb_pkg::DIV_RST;
          bit_ff <= 3'd0;
          cnt_ff <= '0;
          eng_clk_ff <= 1'b0;
          eng_do_ff <= 1'b0;
          adapt_ff <= 1'b0;
        end
      end
    end
  endgenerate

  // pin drive; strobes never reach the pins
  always_comb begin
    case (i_cfg.mode)
      cmb_pkg::MODE_ABB: nxt_oe_n = ~i_cfg.dir;
      cmb_pkg::MODE_SBB: nxt_oe_n = ~i_cfg.dir;
      cmb_pkg::MODE_ENG: nxt_oe_n = ~((i_cfg.dir & ~(adapt_ff ? 8'h80 : 8'h00)) | cmb_pkg::ENG_OUT_MASK);
      default: nxt_oe_n = 8'hff;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pin_out <= 8'h00;
      o_pin_oe_n <= 8'hff;
    end else begin
      o_pin_oe_n <= nxt_oe_n;
      if (abb_load || !read_strobe_n) begin
        o_pin_out <= dn_data;
      end else if (i_cfg.mode == cmb_pkg::MODE_ENG) begin
        o_pin_out[cmb_pkg::PIN_CLK] <= eng_clk_ff;
        o_pin_out[cmb_pkg::PIN_DOUT] <= eng_do_ff;
      end
    end
  end
endmodule

module cmb_channel_io (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] i_cfg_rs485_en,
  input wire logic i_usb_suspend,
  output logic o_power_enable_n,
  input wire logic [3:0] i_baud_tick,
  input wire logic [3:0] i_uart_busy,
  input wire logic [3:0] i_uart_tx_ready,
  output wire logic [3:0] o_uart_tx_valid,
  output wire logic [3:0][7:0] o_uart_tx_data,
  input wire logic [3:0] i_uart_rx_valid,
  input wire logic [3:0][7:0] i_uart_rx_data,
  input wire logic [3:0] i_host_wr_valid,
  input wire logic [3:0][7:0] i_host_wr_data,
  output wire logic [3:0] o_host_wr_ready,
  output wire logic [3:0] o_host_rd_valid,
  output wire logic [3:0][7:0] o_host_rd_data,
  input wire logic [3:0] i_host_rd_ready,
  input wire logic [3:0][7:0] i_pin_in,
  output wire logic [3:0][7:0] o_pin_out,
  output wire logic [3:0][7:0] o_pin_oe_n,
  output wire logic [3:0] o_rs485_driver_enable
);
  cmb_pkg::cmb_mode_e mode_ff [cmb_pkg::NUM_CH];
  logic [7:0] dir_ff [cmb_pkg::NUM_CH];
  cmb_pkg::cmb_stat_s stat [cmb_pkg::NUM_CH];
  logic wr_en;
  logic [1:0] ch_sel;
  logic [31:0] nxt_prdata;
  logic nxt_err;

  assign wr_en = psel && penable && pready && pwrite && !pslverr;
  assign ch_sel = paddr[3:2];

  function automatic logic [7:0] mode_code(input cmb_pkg::cmb_mode_e m);
    case (m)
      cmb_pkg::MODE_ABB: mode_code = cmb_pkg::CODE_ABB;
      cmb_pkg::MODE_ENG: mode_code = cmb_pkg::CODE_ENG;
      cmb_pkg::MODE_SBB: mode_code = cmb_pkg::CODE_SBB;
      default: mode_code = cmb_pkg::CODE_UART;
    endcase
  endfunction

  // apb read mux and decode
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    nxt_err = 1'b0;
    if (paddr[11:4] == cmb_pkg::MODE_BASE[11:4] && paddr[1:0] == 2'b00) begin
      nxt_prdata = {24'h00_0000, mode_code(mode_ff[ch_sel])};
    end else if (paddr[11:4] == cmb_pkg::DIR_BASE[11:4] && paddr[1:0] == 2'b00) begin
      nxt_prdata = {24'h00_0000, dir_ff[ch_sel]};
    end else if (paddr == cmb_pkg::PINS_OFF) begin
      nxt_prdata = {i_pin_in[3], i_pin_in[2], i_pin_in[1], i_pin_in[0]};
    end else if (paddr == cmb_pkg::STAT_OFF) begin
      nxt_prdata = {24'h00_0000, stat[3].rs485_on, stat[2].rs485_on, stat[1].rs485_on, stat[0].rs485_on,
                    stat[3].adaptive, stat[2].adaptive, stat[1].adaptive, stat[0].adaptive};
    end else begin
      nxt_err = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (nxt_err || (pwrite && paddr == cmb_pkg::PINS_OFF));
      prdata <= (psel && !penable && !pwrite) ? nxt_prdata : 32'h0000_0000;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_power_enable_n <= 1'b1;
    end else begin
      o_power_enable_n <= i_usb_suspend;
    end
  end

  genvar g;
  generate
    for (g = 0; g < cmb_pkg::NUM_CH; g++) begin : g_ch
      // per-channel mode, reset to uart; host must reselect after reset
      always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          mode_ff[g] <= cmb_pkg::MODE_UART;
          dir_ff[g] <= cmb_pkg::DIR_RST;
        end else if (wr_en && ch_sel == 2'(g)) begin
          if (paddr[11:4] == cmb_pkg::MODE_BASE[11:4]) begin
            case (pwdata[7:0])
              cmb_pkg::CODE_UART: mode_ff[g] <= cmb_pkg::MODE_UART;
              cmb_pkg::CODE_ABB: mode_ff[g] <= cmb_pkg::MODE_ABB;
              cmb_pkg::CODE_ENG: begin
                if (g < cmb_pkg::NUM_ENG_CH) begin
                  mode_ff[g] <= cmb_pkg::MODE_ENG;
                end
              end
              cmb_pkg::CODE_SBB: mode_ff[g] <= cmb_pkg::MODE_SBB;
              default: mode_ff[g] <= mode_ff[g];
            endcase
          end else if (paddr[11:4] == cmb_pkg::DIR_BASE[11:4]) begin
            dir_ff[g] <= pwdata[7:0];
          end
        end
      end

      cmb_chan #(
        .HAS_ENGINE(g < cmb_pkg::NUM_ENG_CH)
      ) u_chan (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_cfg({mode_ff[g], dir_ff[g], i_cfg_rs485_en[g]}),
        .i_baud_tick(i_baud_tick[g]),
        .i_uart_busy(i_uart_busy[g]),
        .i_uart_tx_ready(i_uart_tx_ready[g]),
        .o_uart_tx_valid(o_uart_tx_valid[g]),
        .o_uart_tx_data(o_uart_tx_data[g]),
        .i_uart_rx_valid(i_uart_rx_valid[g]),
        .i_uart_rx_data(i_uart_rx_data[g]),
        .i_host_wr_valid(i_host_wr_valid[g]),
        .i_host_wr_data(i_host_wr_data[g]),
        .o_host_wr_ready(o_host_wr_ready[g]),
        .o_host_rd_valid(o_host_rd_valid[g]),
        .o_host_rd_data(o_host_rd_data[g]),
        .i_host_rd_ready(i_host_rd_ready[g]),
        .i_pin_in(i_pin_in[g]),
        .o_pin_out(o_pin_out[g]),
        .o_pin_oe_n(o_pin_oe_n[g]),
        .o_stat(stat[g])
      );
      assign o_rs485_driver_enable[g] = stat[g].rs485_on;
    end
  endgenerate
endmodule

`default_nettype wire

// ---- cmb_target.sv ----
// far-side target on the channel pins: drives undriven pins, returns the engine clock
// assumes pin vectors of cmb_channel_io, one clock
`timescale 1ns/1ps
`default_nettype none
module cmb_target (
  input wire logic i_sys_clk,
  input wire logic i_slow,
  input wire logic [3:0][7:0] i_ext,
  input wire logic [3:0][7:0] i_pin_out,
  input wire logic [3:0][7:0] i_pin_oe_n,
  output logic [3:0][7:0] o_pin_in
);
  logic [1:0][3:0] clk_sh_ff;
  // return clock, one or four cycles late
  always_ff @(posedge i_sys_clk) begin
    for (int k = 0; k < 2; k++) begin
      clk_sh_ff[k] <= {clk_sh_ff[k][2:0], i_pin_out[k][0]};
    end
  end
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 8; j++) begin
        o_pin_in[k][j] = i_pin_oe_n[k][j] ? i_ext[k][j] : i_pin_out[k][j];
      end
      if (k < 2 && i_pin_oe_n[k][7]) begin
        o_pin_in[k][7] = i_slow ? clk_sh_ff[k][3] : clk_sh_ff[k][0];
      end
      // data in looped from data out
      if (k < 2 && i_pin_oe_n[k][2]) begin
        o_pin_in[k][2] = i_pin_out[k][1];
      end
    end
  end
endmodule
`default_nettype wire

// ---- cmb_channel_io_chk.sv ----
// checker: apb timing, power enable, rs485 enable, return stream
// assumes binding into cmb_channel_io, one clock domain
`timescale 1ns/1ps
`default_nettype none
module cmb_channel_io_chk (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic i_usb_suspend,
  input wire logic o_power_enable_n,
  input wire logic [3:0] i_cfg_rs485_en,
  input wire logic [3:0] i_uart_busy,
  input wire logic [3:0] o_rs485_driver_enable,
  input wire logic [3:0] o_host_rd_valid,
  input wire logic [3:0] i_host_rd_ready,
  input wire logic [3:0][7:0] o_host_rd_data,
  input wire logic [3:0][7:0] o_pin_oe_n
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata outside access");
  a_power_follows_suspend: assert property ($past(i_nrst) |-> o_power_enable_n == $past(i_usb_suspend))
    else $error("power enable not following suspend");
  a_rs485_needs_busy: assert property ($past(i_nrst) |->
    (o_rs485_driver_enable & ~$past(i_uart_busy & i_cfg_rs485_en)) == 4'h0)
    else $error("rs485 enable without busy");
  a_rs485_uart_only: assert property (o_rs485_driver_enable[1] |->
    o_pin_oe_n[1] == 8'hff || $past(o_pin_oe_n[1]) == 8'hff)
    else $error("rs485 enable outside uart mode");
  a_rd_valid_holds: assert property (o_host_rd_valid[3] && !i_host_rd_ready[3] |=>
    o_host_rd_valid[3] && $stable(o_host_rd_data[3]))
    else $error("return byte dropped");
endmodule
bind cmb_channel_io cmb_channel_io_chk cmb_channel_io_chk_i (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .i_usb_suspend(i_usb_suspend), .o_power_enable_n(o_power_enable_n), .i_cfg_rs485_en(i_cfg_rs485_en),
  .i_uart_busy(i_uart_busy), .o_rs485_driver_enable(o_rs485_driver_enable), .o_host_rd_valid(o_host_rd_valid),
  .i_host_rd_ready(i_host_rd_ready), .o_host_rd_data(o_host_rd_data), .o_pin_oe_n(o_pin_oe_n));
`default_nettype wire

// ---- channel_mode_bitbang_io_bench.sv ----
// testbench: apb and host stream tasks, reference model of modes and pins
// assumes cmb_channel_io, cmb_target and the bound checker
`timescale 1ns/1ps
`default_nettype none
module channel_mode_bitbang_io_bench;
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, susp = 1'b0, slow = 1'b0, mon = 1'b0, dprev = 1'b0, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, r;
  logic [3:0] cfg_en = 4'h0, tick = 4'h0, busy = 4'h0, wr_v = 4'h0, rd_r = 4'h0, rxv = 4'h0;
  logic [3:0][7:0] wr_d = '0, ext = '0;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, pwr_n;
  wire logic [3:0] wr_rdy, rd_v, txen, tx_v;
  wire logic [3:0][7:0] rd_d, pin_o, oe_n, pin_i, tx_d;
  int n_errors = 0, n_tests = 0, cyc = 0;
  int m[4] = '{0, 0, 0, 0};
  logic [7:0] lastp[4] = '{8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] codes[5] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h03};
  logic [7:0] q[$];
  logic [7:0] b, v, dr;
  cmb_channel_io cmb_channel_io_i (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .i_cfg_rs485_en(cfg_en), .i_usb_suspend(susp), .o_power_enable_n(pwr_n), .i_baud_tick(tick),
    .i_uart_busy(busy), .i_uart_tx_ready(4'hf), .o_uart_tx_valid(tx_v), .o_uart_tx_data(tx_d), .i_uart_rx_valid(rxv),
    .i_uart_rx_data(wr_d), .i_host_wr_valid(wr_v), .i_host_wr_data(wr_d), .o_host_wr_ready(wr_rdy),
    .o_host_rd_valid(rd_v), .o_host_rd_data(rd_d), .i_host_rd_ready(rd_r), .i_pin_in(pin_i),
    .o_pin_out(pin_o), .o_pin_oe_n(oe_n), .o_rs485_driver_enable(txen));
  cmb_target cmb_target_i (.i_sys_clk(i_sys_clk), .i_slow(slow), .i_ext(ext), .i_pin_out(pin_o),
    .i_pin_oe_n(oe_n), .o_pin_in(pin_i));
  always #5 i_sys_clk = ~i_sys_clk;
  task automatic summarize();
    if (n_errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
    n_tests++;
    if (s !== x) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_sys_clk);
    penable <= 1'b1;
    do @(posedge i_sys_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk("reg", x, r);
  endtask
  task automatic mode(input int k, input logic [7:0] c);
    apb(1'b1, 12'(cmb_pkg::MODE_BASE + 4 * k), {24'h0, c});
  endtask
  task automatic push(input int k, input logic [7:0] d);
    @(posedge i_sys_clk);
    wr_v[k] <= 1'b1;
    wr_d[k] <= d;
    do @(posedge i_sys_clk); while (wr_rdy[k] !== 1'b1);
    wr_v[k] <= 1'b0;
  endtask
  task automatic pull(input int k);
    @(posedge i_sys_clk);
    rd_r[k] <= 1'b1;
    do @(posedge i_sys_clk); while (rd_v[k] !== 1'b1);
    v = rd_d[k];
    rd_r[k] <= 1'b0;
  endtask
  task automatic wait_settle(input int n);
    repeat (n) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
  endtask
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      summarize();
    end
  end
  // data out may move only once the returned clock is low
  always @(negedge i_sys_clk) begin
    if (mon && pin_o[0][1] !== dprev) chk("adapt_wait", 32'h0, 32'(pin_i[0][7]));
    dprev = pin_o[0][1];
  end
  initial begin
    void'($urandom(32'h2c95));
    repeat (16) @(posedge i_sys_clk);
    chk("oe_rst", 32'hffffffff, oe_n);
    i_nrst <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      rdc(12'(cmb_pkg::MODE_BASE + 4 * k), 32'h0);
      rdc(12'(cmb_pkg::DIR_BASE + 4 * k), {24'h0, cmb_pkg::DIR_RST});
    end
    rdc(cmb_pkg::STAT_OFF, 32'h0);
    apb(1'b0, 12'h030, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e});
    for (int k = 0; k < 4; k++) begin
      foreach (codes[i]) begin
        mode(k, codes[i]);
        if (codes[i] != 8'h03 && !(codes[i] == 8'h02 && k > 1)) m[k] = int'(codes[i]);
        for (int j = 0; j < 4; j++) rdc(12'(cmb_pkg::MODE_BASE + 4 * j), 32'(m[j]));
      end
    end
    mode(1, cmb_pkg::CODE_UART);
    cfg_en <= 4'h3;
    @(posedge i_sys_clk);
    busy <= 4'h3;
    wait_settle(1);
    chk("txen_on", 32'h2, {28'h0, txen});
    @(posedge i_sys_clk);
    busy <= 4'h0;
    susp <= 1'b1;
    wait_settle(1);
    chk("txen_off", 32'h0, {28'h0, txen});
    chk("pwr", 32'h1, {31'h0, pwr_n});
    @(posedge i_sys_clk);
    susp <= 1'b0;
    b = 8'($urandom);
    push(1, b);
    wait_settle(1);
    chk("uart_tx", {24'h1, b}, {23'h0, tx_v[1], tx_d[1]});
    @(posedge i_sys_clk);
    rxv <= 4'h2;
    @(posedge i_sys_clk);
    rxv <= 4'h0;
    pull(1);
    chk("uart_rx", 32'(b), 32'(v));
    dr = 8'($urandom) | 8'h01;
    apb(1'b1, 12'(cmb_pkg::DIR_BASE + 8), {24'h0, dr});
    mode(2, cmb_pkg::CODE_ABB);
    for (int i = 0; i < 2; i++) begin
      b = 8'($urandom);
      push(2, b);
      q.push_back(b);
    end
    wait_settle(4);
    chk("abb_hold", 32'(lastp[2] & dr), 32'(pin_o[2] & dr));
    while (q.size() > 0) begin
      @(posedge i_sys_clk);
      tick[2] <= 1'b1;
      @(posedge i_sys_clk);
      tick[2] <= 1'b0;
      wait_settle(1);
      lastp[2] = q.pop_front();
      chk("abb_pin", 32'(lastp[2] & dr), 32'(pin_o[2] & dr));
    end
    chk("abb_oe", {24'h0, ~dr}, 32'(oe_n[2]));
    apb(1'b1, 12'(cmb_pkg::DIR_BASE + 12), 32'h0f);
    ext[3] <= 8'($urandom);
    for (int i = 0; i < 3; i++) begin
      b = 8'($urandom);
      push(3, b);
      q.push_back((lastp[3] & 8'h0f) | (ext[3] & 8'hf0));
      lastp[3] = b;
    end
    wait_settle(8);
    while (q.size() > 0) begin
      pull(3);
      chk("sbb_rd", 32'(q.pop_front()), 32'(v));
    end
    chk("sbb_pin", 32'(lastp[3] & 8'h0f), 32'(pin_o[3] & 8'h0f));
    slow <= 1'b1;
    apb(1'b1, cmb_pkg::DIR_BASE, 32'h80);
    mode(0, cmb_pkg::CODE_ENG);
    push(0, cmb_pkg::OP_DIV);
    push(0, 8'h00);
    push(0, cmb_pkg::OP_ADAPT_ON);
    wait_settle(4);
    apb(1'b0, cmb_pkg::STAT_OFF, 32'h0);
    chk("adapt_on", 32'h1, 32'(r[0]));
    mon <= 1'b1;
    b = 8'($urandom);
    push(0, cmb_pkg::OP_SHIFT);
    push(0, b);
    pull(0);
    chk("shift", 32'(b), 32'(v));
    chk("retclk_in", 32'h1, 32'(oe_n[0][7]));
    mon <= 1'b0;
    mode(0, cmb_pkg::CODE_UART);
    wait_settle(2);
    chk("uart_oe", 32'hff, 32'(oe_n[0]));
    i_nrst <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    for (int k = 0; k < 4; k++) rdc(12'(cmb_pkg::MODE_BASE + 4 * k), 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
